/* rtl/idt_pkg.sv */
// Shared constants, types and helpers for the isochronous stream link ends
// Contract
// - Host drops OUT packets past presentation time
// - OUT receiver infers drops from presentation times
// - Each data packet carries sequence and presentation time
// - Sequence numbers keep send/accept windows aligned
// - Device consumes data at its presentation time
// - Host stamps channel time in every control message
// - IN endpoint NAKs requests before start time
// - At start time IN endpoint produces, answers normally
// - Packet header holds one time, some segments
// - Header time belongs to first segment only
// - Later segments step by one service interval
// - IN presentation time is production channel time
// - Host sets OUT time to consumption channel time
// - Dropped IN time is never reused later
// - Full IN buffer drops oldest for newest
// - Next IN packet reuses dropped packet's sequence
// - Replacement differs only in time and payload
// - Host resends newer OUT data in same slot
// - Receiver detects overflow and counts lost packets
package idt_pkg;

  // Widths
  localparam int SEQ_W = 3;
  localparam int PT_W = 16;
  localparam int DATA_W = 32;
  localparam int NSEG_W = 2;
  localparam int SHIFT_W = 4;
  localparam int IN_DEPTH = 8;
  localparam int IN_PTR_W = 3;
  localparam int IN_CNT_W = 4;

  // Timing: channel time advances one tick per microsecond
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 1000;
  localparam logic [6:0] TICK_LAST = 7'(TICK_NS / CLK_PERIOD_NS - 1);
  localparam logic [7:0] MMC_PERIOD_TICKS = 8'h40;
  localparam logic [4:0] OUT_RETRY_CYCLES = 5'h10;

  // Reset values and the full IN buffer count
  localparam logic [PT_W-1:0] CTIME_RST = 16'h0000;
  localparam logic [SEQ_W-1:0] SEQ_RST = 3'h0;
  localparam logic [IN_CNT_W-1:0] IN_FULL = 4'h8;

  // Host to device message kinds
  typedef enum logic [2:0] {
    IDT_H2D_NONE,
    IDT_H2D_MMC,
    IDT_H2D_OUT,
    IDT_H2D_INREQ,
    IDT_H2D_INACK
  } idt_h2d_t;

  // Device to host answers
  typedef enum logic [1:0] {
    IDT_D2H_NONE,
    IDT_D2H_ACK,
    IDT_D2H_DATA,
    IDT_D2H_NAK
  } idt_d2h_t;

  // True once channel time now has reached t, tolerant of wrap
  function automatic logic idt_reached(input logic [PT_W-1:0] now, input logic [PT_W-1:0] t);
    logic [PT_W-1:0] diff;
    diff = now - t;
    return ~diff[PT_W-1];
  endfunction : idt_reached

  // Packets missing between the expected and the received time
  function automatic logic [PT_W-1:0] idt_lost(input logic [PT_W-1:0] want,
                                               input logic [PT_W-1:0] got,
                                               input logic [SHIFT_W-1:0] shift);
    logic [PT_W-1:0] gap;
    gap = got - want;
    if (gap[PT_W-1]) begin
      return '0;
    end
    return gap >> shift;
  endfunction : idt_lost

  // Length in ticks of n service intervals
  function automatic logic [PT_W-1:0] idt_span(input logic [NSEG_W-1:0] n,
                                               input logic [SHIFT_W-1:0] shift);
    return {{(PT_W-NSEG_W){1'b0}}, n} << shift;
  endfunction : idt_span

endpackage : idt_pkg

/* rtl/idt_link.sv */
// Message link joining the host end and the device end
`timescale 1ns/100ps
interface idt_link;
  import idt_pkg::*;

  // Host to device, one message per cycle
  idt_h2d_t h2d_kind;
  logic [SEQ_W-1:0] h2d_seq;
  logic [PT_W-1:0] h2d_pt;
  logic [NSEG_W-1:0] h2d_nseg;
  logic [DATA_W-1:0] h2d_data;

  // Device to host, one answer per cycle
  idt_d2h_t d2h_kind;
  logic [SEQ_W-1:0] d2h_seq;
  logic [PT_W-1:0] d2h_pt;
  logic [DATA_W-1:0] d2h_data;

  modport host (
    output h2d_kind, h2d_seq, h2d_pt, h2d_nseg, h2d_data,
    input d2h_kind, d2h_seq, d2h_pt, d2h_data
  );

  modport dev (
    input h2d_kind, h2d_seq, h2d_pt, h2d_nseg, h2d_data,
    output d2h_kind, d2h_seq, d2h_pt, d2h_data
  );

endinterface : idt_link

/* rtl/idt_dev.sv */
// Device end: isochronous OUT receiver and gated isochronous IN source
`timescale 1ns/100ps
module idt_dev (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Link to host
  idt_link.dev lnk,
  // Stream configuration
  input wire logic [idt_pkg::SHIFT_W-1:0] svc_shift,
  input wire logic start_armed,
  input wire logic [idt_pkg::PT_W-1:0] start_time,
  // OUT consumer side
  output logic seg_valid,
  output logic [idt_pkg::DATA_W-1:0] seg_data,
  output logic [idt_pkg::PT_W-1:0] seg_pt,
  output logic [idt_pkg::PT_W-1:0] lost_cnt,
  output logic discard_evt,
  // IN producer side
  input wire logic prod_valid,
  input wire logic [idt_pkg::DATA_W-1:0] prod_data,
  output logic in_running,
  output logic in_drop,
  // Channel time
  output logic [idt_pkg::PT_W-1:0] ctime
);
  import idt_pkg::*;

  typedef struct packed {
    logic [PT_W-1:0] ctime;
    logic [6:0] tick;
    // OUT receive window
    logic [SEQ_W-1:0] exp_seq;
    logic have_last;
    logic [PT_W-1:0] next_pt;
    logic pend;
    logic [PT_W-1:0] pend_pt;
    logic [NSEG_W-1:0] pend_segs;
    logic [DATA_W-1:0] pend_data;
    logic seg_valid;
    logic [DATA_W-1:0] seg_data;
    logic [PT_W-1:0] seg_pt;
    logic [PT_W-1:0] lost_cnt;
    logic discard_evt;
    // IN source
    logic running;
    logic [SEQ_W-1:0] in_seq;
    logic [IN_PTR_W-1:0] head;
    logic [IN_PTR_W-1:0] tail;
    logic [IN_CNT_W-1:0] count;
    logic [IN_DEPTH-1:0][PT_W-1:0] buf_pt;
    logic [IN_DEPTH-1:0][DATA_W-1:0] buf_data;
    logic in_drop;
    // Answer to host
    idt_d2h_t rsp_kind;
    logic [SEQ_W-1:0] rsp_seq;
    logic [PT_W-1:0] rsp_pt;
    logic [DATA_W-1:0] rsp_data;
  } idt_dev_st_t;

  idt_dev_st_t st_q;
  idt_dev_st_t st_d;

  // Next-state logic for the whole device end
  always_comb begin
    logic pop;
    logic push;
    pop = 1'b0;
    push = 1'b0;
    st_d = st_q;
    st_d.seg_valid = 1'b0;
    st_d.discard_evt = 1'b0;
    st_d.in_drop = 1'b0;
    st_d.rsp_kind = IDT_D2H_NONE;

    // Channel time runs locally and is corrected by every control message
    if (st_q.tick == TICK_LAST) begin
      st_d.tick = '0;
      st_d.ctime = st_q.ctime + 16'h0001;
    end else begin
      st_d.tick = st_q.tick + 7'h01;
    end
    if (lnk.h2d_kind == IDT_H2D_MMC) begin
      st_d.ctime = lnk.h2d_pt;
      st_d.tick = '0;
    end

    // Consume each segment when channel time reaches its time
    if (st_q.pend && idt_reached(st_q.ctime, st_q.pend_pt)) begin
      st_d.seg_valid = 1'b1;
      st_d.seg_data = st_q.pend_data;
      st_d.seg_pt = st_q.pend_pt;
      st_d.pend_pt = st_q.pend_pt + idt_span(2'h1, svc_shift);
      st_d.pend_segs = st_q.pend_segs - 2'h1;
      if (st_q.pend_segs == 2'h1) begin
        st_d.pend = 1'b0;
      end
    end

    // OUT packets: accept only the expected sequence number
    if (lnk.h2d_kind == IDT_H2D_OUT && lnk.h2d_nseg != '0) begin
      if (lnk.h2d_seq == st_q.exp_seq && !st_q.pend) begin
        // Header time is the first segment's time
        st_d.pend = 1'b1;
        st_d.pend_pt = lnk.h2d_pt;
        st_d.pend_segs = lnk.h2d_nseg;
        st_d.pend_data = lnk.h2d_data;
        st_d.exp_seq = st_q.exp_seq + 3'h1;
        st_d.have_last = 1'b1;
        st_d.next_pt = lnk.h2d_pt + idt_span(lnk.h2d_nseg, svc_shift);
        // A gap in presentation time reveals host discards
        st_d.lost_cnt = st_q.have_last ? idt_lost(st_q.next_pt, lnk.h2d_pt, svc_shift) : '0;
        st_d.discard_evt = st_q.have_last &&
                           (idt_lost(st_q.next_pt, lnk.h2d_pt, svc_shift) != '0);
        st_d.rsp_kind = IDT_D2H_ACK;
        st_d.rsp_seq = lnk.h2d_seq;
      end else if (st_q.have_last && lnk.h2d_seq == st_q.exp_seq - 3'h1) begin
        // Our last ACK was lost; confirm again without storing
        st_d.rsp_kind = IDT_D2H_ACK;
        st_d.rsp_seq = lnk.h2d_seq;
      end
    end

    // IN start gate: armed streams wait for the configured time
    if (!start_armed || idt_reached(st_q.ctime, start_time)) begin
      st_d.running = 1'b1;
    end

    // IN data request
    if (lnk.h2d_kind == IDT_H2D_INREQ) begin
      if (!st_q.running || st_q.count == '0) begin
        st_d.rsp_kind = IDT_D2H_NAK;
        st_d.rsp_seq = st_q.in_seq;
      end else begin
        // Head is sent under the current slot's sequence number
        st_d.rsp_kind = IDT_D2H_DATA;
        st_d.rsp_seq = st_q.in_seq;
        st_d.rsp_pt = st_q.buf_pt[st_q.head];
        st_d.rsp_data = st_q.buf_data[st_q.head];
      end
    end

    // Host acknowledged: slot advances; pop only if the head was what it got
    if (lnk.h2d_kind == IDT_H2D_INACK && lnk.h2d_seq == st_q.in_seq) begin
      st_d.in_seq = st_q.in_seq + 3'h1;
      pop = (st_q.count != '0) && (st_q.buf_pt[st_q.head] == lnk.h2d_pt);
    end

    // Production is stamped with the channel time it happened at
    push = prod_valid && st_q.running;
    if (push) begin
      st_d.buf_pt[st_q.tail] = st_q.ctime;
      st_d.buf_data[st_q.tail] = prod_data;
      st_d.tail = st_q.tail + 3'h1;
    end

    // Full buffer loses its oldest entry; its time goes with it
    if (push && !pop && st_q.count == IN_FULL) begin
      st_d.head = st_q.head + 3'h1;
      st_d.in_drop = 1'b1;
    end else begin
      if (pop) begin
        st_d.head = st_q.head + 3'h1;
      end
      if (push && !pop) begin
        st_d.count = st_q.count + 4'h1;
      end else if (pop && !push) begin
        st_d.count = st_q.count - 4'h1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.ctime <= CTIME_RST;
      st_q.exp_seq <= SEQ_RST;
      st_q.in_seq <= SEQ_RST;
      st_q.rsp_kind <= IDT_D2H_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from state
  assign lnk.d2h_kind = st_q.rsp_kind;
  assign lnk.d2h_seq = st_q.rsp_seq;
  assign lnk.d2h_pt = st_q.rsp_pt;
  assign lnk.d2h_data = st_q.rsp_data;
  assign seg_valid = st_q.seg_valid;
  assign seg_data = st_q.seg_data;
  assign seg_pt = st_q.seg_pt;
  assign lost_cnt = st_q.lost_cnt;
  assign discard_evt = st_q.discard_evt;
  assign in_running = st_q.running;
  assign in_drop = st_q.in_drop;
  assign ctime = st_q.ctime;

endmodule : idt_dev

/* rtl/idt_host.sv */
// Host end: control message timing, OUT scheduling with discard, IN polling
`timescale 1ns/100ps
module idt_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Link to device
  idt_link.host lnk,
  // Stream configuration
  input wire logic [idt_pkg::SHIFT_W-1:0] svc_shift,
  // OUT source side
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [idt_pkg::DATA_W-1:0] out_data,
  input wire logic [idt_pkg::PT_W-1:0] out_pt,
  input wire logic [idt_pkg::NSEG_W-1:0] out_nseg,
  output logic out_drop,
  // IN sink side
  input wire logic in_poll,
  output logic in_valid,
  output logic [idt_pkg::DATA_W-1:0] in_data,
  output logic [idt_pkg::PT_W-1:0] in_pt,
  output logic [idt_pkg::PT_W-1:0] in_lost,
  output logic in_discard,
  // Channel time
  output logic [idt_pkg::PT_W-1:0] ctime
);
  import idt_pkg::*;

  typedef struct packed {
    logic [PT_W-1:0] ctime;
    logic [6:0] tick;
    logic [7:0] mmc_cnt;
    logic mmc_due;
    // OUT slot
    logic hold;
    logic [SEQ_W-1:0] out_seq;
    logic [PT_W-1:0] hold_pt;
    logic [NSEG_W-1:0] hold_nseg;
    logic [DATA_W-1:0] hold_data;
    logic [4:0] wait_cnt;
    logic out_drop;
    // IN side
    logic poll_pend;
    logic ack_pend;
    logic [SEQ_W-1:0] ack_seq;
    logic [PT_W-1:0] ack_pt;
    logic have_last;
    logic [PT_W-1:0] next_pt;
    logic in_valid;
    logic [DATA_W-1:0] in_data;
    logic [PT_W-1:0] in_pt;
    logic [PT_W-1:0] in_lost;
    logic in_discard;
    // Message to device
    idt_h2d_t kind;
    logic [SEQ_W-1:0] seq;
    logic [PT_W-1:0] pt;
    logic [NSEG_W-1:0] nseg;
    logic [DATA_W-1:0] data;
  } idt_host_st_t;

  idt_host_st_t st_q;
  idt_host_st_t st_d;

  // Next-state logic for the whole host end
  always_comb begin
    st_d = st_q;
    st_d.out_drop = 1'b0;
    st_d.in_valid = 1'b0;
    st_d.in_discard = 1'b0;
    st_d.kind = IDT_H2D_NONE;
    if (st_q.wait_cnt != '0) begin
      st_d.wait_cnt = st_q.wait_cnt - 5'h01;
    end

    // Channel time base and control message cadence
    if (st_q.tick == TICK_LAST) begin
      st_d.tick = '0;
      st_d.ctime = st_q.ctime + 16'h0001;
      st_d.mmc_cnt = st_q.mmc_cnt + 8'h01;
      if (st_q.mmc_cnt == MMC_PERIOD_TICKS - 8'h01) begin
        st_d.mmc_cnt = '0;
        st_d.mmc_due = 1'b1;
      end
    end else begin
      st_d.tick = st_q.tick + 7'h01;
    end

    // Take a new OUT packet into the single slot; time set by the source
    if (out_valid && !st_q.hold) begin
      st_d.hold = 1'b1;
      st_d.hold_pt = out_pt;
      st_d.hold_nseg = out_nseg;
      st_d.hold_data = out_data;
      st_d.wait_cnt = '0;
    end

    // Device answers
    if (lnk.d2h_kind == IDT_D2H_ACK && st_q.hold && lnk.d2h_seq == st_q.out_seq) begin
      st_d.hold = 1'b0;
      st_d.out_seq = st_q.out_seq + 3'h1;
    end else if (st_q.hold && idt_reached(st_q.ctime, st_q.hold_pt)) begin
      // Expired: give up, keep the slot's sequence for newer data
      st_d.hold = 1'b0;
      st_d.out_drop = 1'b1;
    end
    if (lnk.d2h_kind == IDT_D2H_DATA) begin
      st_d.in_valid = 1'b1;
      st_d.in_data = lnk.d2h_data;
      st_d.in_pt = lnk.d2h_pt;
      // Gaps in produced times show device-side overflow
      st_d.in_lost = st_q.have_last ? idt_lost(st_q.next_pt, lnk.d2h_pt, svc_shift) : '0;
      st_d.in_discard = st_q.have_last &&
                        (idt_lost(st_q.next_pt, lnk.d2h_pt, svc_shift) != '0);
      st_d.have_last = 1'b1;
      st_d.next_pt = lnk.d2h_pt + idt_span(2'h1, svc_shift);
      st_d.ack_pend = 1'b1;
      st_d.ack_seq = lnk.d2h_seq;
      st_d.ack_pt = lnk.d2h_pt;
    end

    // One message a cycle: control message, ack, OUT data, then IN request
    if (st_q.mmc_due) begin
      st_d.mmc_due = 1'b0;
      st_d.kind = IDT_H2D_MMC;
      st_d.pt = st_q.ctime;
    end else if (st_q.ack_pend) begin
      st_d.ack_pend = 1'b0;
      st_d.kind = IDT_H2D_INACK;
      st_d.seq = st_q.ack_seq;
      st_d.pt = st_q.ack_pt;
    end else if (st_q.hold && st_q.wait_cnt == '0 && !idt_reached(st_q.ctime, st_q.hold_pt)) begin
      // Retries are spaced so that an answer can come back first
      st_d.kind = IDT_H2D_OUT;
      st_d.seq = st_q.out_seq;
      st_d.pt = st_q.hold_pt;
      st_d.nseg = st_q.hold_nseg;
      st_d.data = st_q.hold_data;
      st_d.wait_cnt = OUT_RETRY_CYCLES;
    end else if (st_q.poll_pend) begin
      st_d.poll_pend = 1'b0;
      st_d.kind = IDT_H2D_INREQ;
    end

    // A poll arriving as the pending one goes out must not be lost
    if (in_poll) begin
      st_d.poll_pend = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.ctime <= CTIME_RST;
      st_q.out_seq <= SEQ_RST;
      st_q.kind <= IDT_H2D_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs; the ready is combinational on the slot flag
  assign out_ready = !st_q.hold;
  assign out_drop = st_q.out_drop;
  assign lnk.h2d_kind = st_q.kind;
  assign lnk.h2d_seq = st_q.seq;
  assign lnk.h2d_pt = st_q.pt;
  assign lnk.h2d_nseg = st_q.nseg;
  assign lnk.h2d_data = st_q.data;
  assign in_valid = st_q.in_valid;
  assign in_data = st_q.in_data;
  assign in_pt = st_q.in_pt;
  assign in_lost = st_q.in_lost;
  assign in_discard = st_q.in_discard;
  assign ctime = st_q.ctime;

endmodule : idt_host

/* tb/idt_link_props.sv */
// Link checker watching the messages between the host end and the device end
`timescale 1ns/100ps
module idt_link_props
  import idt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Host to device
  input wire idt_h2d_t h2d_kind,
  input wire logic [SEQ_W-1:0] h2d_seq,
  input wire logic [PT_W-1:0] h2d_pt,
  input wire logic [NSEG_W-1:0] h2d_nseg,
  input wire logic [DATA_W-1:0] h2d_data,
  // Device to host
  input wire idt_d2h_t d2h_kind,
  input wire logic [SEQ_W-1:0] d2h_seq,
  input wire logic [PT_W-1:0] d2h_pt,
  input wire logic [DATA_W-1:0] d2h_data
);
  logic have_q;
  logic [SEQ_W-1:0] dseq_q;
  logic [PT_W-1:0] dpt_q;
  logic [DATA_W-1:0] ddat_q;
  logic [13:0] mmc_gap_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Last IN packet offered, so a stamp given to another packet shows up
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      have_q <= 1'b0;
      dseq_q <= '0;
      dpt_q <= '0;
      ddat_q <= '0;
      mmc_gap_q <= '0;
    end else begin
      if (d2h_kind == IDT_D2H_DATA) begin
        have_q <= 1'b1;
        dseq_q <= d2h_seq;
        dpt_q <= d2h_pt;
        ddat_q <= d2h_data;
      end
      mmc_gap_q <= (h2d_kind == IDT_H2D_MMC) ? 14'h0000 : mmc_gap_q + 14'h0001;
    end
  end

  AST_INREQ_ANSWERED: assert property (h2d_kind == IDT_H2D_INREQ |=>
    d2h_kind inside {IDT_D2H_DATA, IDT_D2H_NAK}) else $error("data request not answered");
  AST_IN_ONLY_ASKED: assert property (d2h_kind inside {IDT_D2H_DATA, IDT_D2H_NAK} |->
    $past(h2d_kind) == IDT_H2D_INREQ) else $error("IN answer without a request");
  AST_ACK_SEQ: assert property (d2h_kind == IDT_D2H_ACK |->
    $past(h2d_kind) == IDT_H2D_OUT && d2h_seq == $past(h2d_seq)) else $error("bad OUT ack");
  AST_OUT_SEGS: assert property (h2d_kind == IDT_H2D_OUT |-> h2d_nseg != 2'h0)
    else $error("OUT packet without segments");
  AST_PT_NOT_REUSED: assert property (d2h_kind == IDT_D2H_DATA && have_q && d2h_pt == dpt_q
    |-> d2h_seq == dseq_q && d2h_data == ddat_q) else $error("IN stamp reused");
  AST_INACK_MATCH: assert property (h2d_kind == IDT_H2D_INACK |->
    have_q && h2d_seq == dseq_q && h2d_pt == dpt_q) else $error("IN ack mismatch");
  AST_DATA_ACKED: assert property (d2h_kind == IDT_D2H_DATA |->
    ##[2:6] h2d_kind == IDT_H2D_INACK) else $error("IN data never acknowledged");
  AST_MMC_DUE: assert property (mmc_gap_q < 14'h2000)
    else $error("control message overdue");
  AST_OUT_RETRY: assert property (h2d_kind == IDT_H2D_OUT ##1 d2h_kind == IDT_D2H_NONE
    |=> (h2d_kind != IDT_H2D_OUT) [*8]) else $error("OUT retried too soon");
endmodule : idt_link_props

/* tb/tb_isoch_discard_timestamp_logic.sv */
// Bench joining the host end and the device end over the message link
`timescale 1ns/100ps
module tb_isoch_discard_timestamp_logic;
  import idt_pkg::*;
  localparam logic [SHIFT_W-1:0] SHIFT = 4'h1;
  localparam logic [PT_W-1:0] IVL = 16'h0002;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic start_armed = 1'b1;
  logic [PT_W-1:0] start_time = 16'h0008;
  logic prod_valid = 1'b0;
  logic [DATA_W-1:0] prod_data = '0;
  logic out_valid = 1'b0;
  logic [DATA_W-1:0] out_data = '0;
  logic [PT_W-1:0] out_pt = '0;
  logic [NSEG_W-1:0] out_nseg = 2'h1;
  logic in_poll = 1'b0;
  logic seg_valid, discard_evt, in_running, in_drop, out_ready, out_drop, in_valid, in_discard;
  logic [DATA_W-1:0] seg_data, in_data;
  logic [PT_W-1:0] seg_pt, lost_cnt, dev_ct, host_ct, in_pt, in_lost, p, pa;
  logic [SEQ_W-1:0] dseq = '0;
  logic [SEQ_W-1:0] aseq = '0;
  logic [SEQ_W-1:0] q0;
  int err_count = 0;
  int num_checks = 0;
  int n_nak = 0, n_drop = 0, n_disc = 0, n_indrop = 0, n_indisc = 0;
  int i, j, k;

  always #4 sys_clk = ~sys_clk;

  idt_link u_idt_link();
  idt_host u_idt_host (.sys_clk(sys_clk), .resetn(resetn), .lnk(u_idt_link), .svc_shift(SHIFT),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_pt(out_pt),
    .out_nseg(out_nseg), .out_drop(out_drop), .in_poll(in_poll), .in_valid(in_valid),
    .in_data(in_data), .in_pt(in_pt), .in_lost(in_lost), .in_discard(in_discard),
    .ctime(host_ct));
  idt_dev u_idt_dev (.sys_clk(sys_clk), .resetn(resetn), .lnk(u_idt_link), .svc_shift(SHIFT),
    .start_armed(start_armed), .start_time(start_time), .seg_valid(seg_valid),
    .seg_data(seg_data), .seg_pt(seg_pt), .lost_cnt(lost_cnt), .discard_evt(discard_evt),
    .prod_valid(prod_valid), .prod_data(prod_data), .in_running(in_running),
    .in_drop(in_drop), .ctime(dev_ct));
  idt_link_props u_idt_link_props (.sys_clk(sys_clk), .resetn(resetn),
    .h2d_kind(u_idt_link.h2d_kind), .h2d_seq(u_idt_link.h2d_seq), .h2d_pt(u_idt_link.h2d_pt),
    .h2d_nseg(u_idt_link.h2d_nseg), .h2d_data(u_idt_link.h2d_data),
    .d2h_kind(u_idt_link.d2h_kind), .d2h_seq(u_idt_link.d2h_seq),
    .d2h_pt(u_idt_link.d2h_pt), .d2h_data(u_idt_link.d2h_data));

  // Pulses are counted here so a test can look at them after the fact
  always @(posedge sys_clk) begin
    if (u_idt_link.d2h_kind === IDT_D2H_NAK) n_nak++;
    if (u_idt_link.d2h_kind === IDT_D2H_DATA) dseq <= u_idt_link.d2h_seq;
    if (u_idt_link.d2h_kind === IDT_D2H_ACK) aseq <= u_idt_link.d2h_seq;
    if (out_drop === 1'b1) n_drop++;
    if (discard_evt === 1'b1) n_disc++;
    if (in_drop === 1'b1) n_indrop++;
    if (in_discard === 1'b1) n_indisc++;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, seen, exp);
    end
  endtask : check_val

  // A used-up bound ends the run rather than hanging it
  task automatic bound(input int n, input int lim, input string what);
    if (n >= lim) begin
      err_count++;
      $display("unexpected at %0t: %s timed out", $time, what);
      tally_and_finish();
    end
  endtask : bound

  // Inputs always move one ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  task automatic wait_ct(input logic [PT_W-1:0] t);
    for (i = 0; i < 20000 && !(dev_ct >= t); i++) step(1);
    bound(i, 20000, "channel time");
  endtask : wait_ct

  task automatic produce(input logic [PT_W-1:0] t, input logic [DATA_W-1:0] d);
    wait_ct(t);
    prod_valid = 1'b1;
    prod_data = d;
    step(1);
    prod_valid = 1'b0;
  endtask : produce

  task automatic poll_data(input logic [DATA_W-1:0] d, input logic [PT_W-1:0] t);
    in_poll = 1'b1;
    step(1);
    in_poll = 1'b0;
    for (j = 0; j < 20 && in_valid !== 1'b1; j++) step(1);
    bound(j, 20, "IN data");
    check_val(in_data, d, "in data");
    check_val(in_pt, t, "in stamp");
    step(4);
  endtask : poll_data

  // Offer is held until the edge that sees out_ready high takes it
  task automatic send_out(input logic [PT_W-1:0] t, input logic [NSEG_W-1:0] n,
                          input logic [DATA_W-1:0] d);
    out_pt = t;
    out_nseg = n;
    out_data = d;
    out_valid = 1'b1;
    for (j = 0; j < 4000 && out_ready !== 1'b1; j++) step(1);
    bound(j, 4000, "out ready");
    step(1);
    out_valid = 1'b0;
    step(1);
  endtask : send_out

  task automatic wait_seg(input logic [PT_W-1:0] t, input logic [DATA_W-1:0] d);
    for (j = 0; j < 4000 && seg_valid !== 1'b1; j++) step(1);
    bound(j, 4000, "segment");
    check_val(seg_pt, t, "segment stamp");
    check_val(seg_data, d, "segment data");
    check_val(dev_ct >= t, 1'b1, "consumed early");
    step(1);
  endtask : wait_seg

  initial begin
    step(12);
    resetn = 1'b1;
    // Gated start: a request before the start time is refused
    in_poll = 1'b1;
    step(1);
    in_poll = 1'b0;
    step(4);
    check_val(n_nak, 32'h1, "early request");
    check_val(in_running, 1'b0, "running early");
    wait_ct(start_time);
    check_val(host_ct, start_time, "host time");
    step(2);
    check_val(in_running, 1'b1, "not started");
    $display("test gated start done");
    // IN stream one sample per interval, overflowing so the oldest goes
    produce(16'h000A, 32'h000000A0);
    poll_data(32'h000000A0, 16'h000A);
    q0 = dseq + 3'h1;
    for (k = 1; k <= 9; k++) produce(16'h000A + PT_W'(k) * IVL, 32'h000000A0 + k);
    poll_data(32'h000000A2, 16'h000E);
    check_val(n_indrop, 32'h1, "oldest dropped");
    check_val(dseq, q0, "slot after drop");
    check_val(in_lost, 16'h0001, "IN lost count");
    check_val(n_indisc, 32'h1, "IN discard");
    for (k = 3; k <= 9; k++) poll_data(32'h000000A0 + k, 16'h000A + PT_W'(k) * IVL);
    $display("test IN overflow done");
    // OUT packets of one, two and three segments in a row
    p = 16'h0024;
    for (k = 1; k <= 3; k++) begin
      send_out(p, NSEG_W'(k), 32'h000000B0 + k);
      for (i = 0; i < k; i++) wait_seg(p + PT_W'(i) * IVL, 32'h000000B0 + k);
      p = p + PT_W'(k) * IVL;
    end
    check_val(lost_cnt, 16'h0000, "no loss");
    $display("test OUT segments done");
    // A held packet blocks a newer one until that one expires at the host
    pa = p + 16'h000C;
    send_out(pa, 2'h1, 32'h000000C1);
    send_out(p + 16'h0004, 2'h1, 32'h000000C2);
    q0 = aseq + 3'h1;
    for (i = 0; i < 4000 && n_drop == 0; i++) step(1);
    bound(i, 4000, "expiry");
    // The held packet jumped ahead of the stream, so its gap counts as loss
    check_val(lost_cnt, (pa - p) / IVL, "gap before held packet");
    check_val(n_disc, 32'h1, "first discard event");
    step(10);
    send_out(pa + 16'h0004, 2'h1, 32'h000000C3);
    wait_seg(pa, 32'h000000C1);
    wait_seg(pa + 16'h0004, 32'h000000C3);
    check_val(aseq, q0, "slot reuse");
    check_val(lost_cnt, 16'h0001, "lost count");
    check_val(n_disc, 32'h2, "discard event");
    $display("test OUT discard done");
    tally_and_finish();
  end
endmodule : tb_isoch_discard_timestamp_logic
